// ==== hdl/tpsc_pkg.sv ====
// shared constants and types for the tuner synthesizer serial control port
package tpsc_pkg;

	// fixed upper part of the slave address byte
	localparam logic [4:0]  TPSC_ADDR_FIXED  = 5'h18;

	// power-on values of the programmed registers
	localparam logic [7:0]  TPSC_CTRL_RESET  = 8'hC8;
	localparam logic [4:0]  TPSC_BAND_RESET  = 5'h00;
	localparam logic [14:0] TPSC_DIV_RESET   = 15'h0000;

	// control byte field positions
	localparam int          TPSC_CB_MARK     = 7;
	localparam int          TPSC_CB_PUMP     = 6;
	localparam int          TPSC_CB_TEST_HI  = 5;
	localparam int          TPSC_CB_TEST_LO  = 3;
	localparam int          TPSC_CB_RSA      = 2;
	localparam int          TPSC_CB_RSB      = 1;
	localparam int          TPSC_CB_BOOST    = 0;

	// test select codes
	localparam logic [2:0]  TPSC_TEST_NORM0  = 3'h0;
	localparam logic [2:0]  TPSC_TEST_NORM1  = 3'h1;
	localparam logic [2:0]  TPSC_TEST_PUMPOFF = 3'h2;
	localparam logic [2:0]  TPSC_TEST_NOBAND = 3'h3;
	localparam logic [2:0]  TPSC_TEST_HALFREF = 3'h4;
	localparam logic [2:0]  TPSC_TEST_HALFDIV = 3'h5;
	localparam logic [2:0]  TPSC_TEST_SINK   = 3'h6;
	localparam logic [2:0]  TPSC_TEST_SOURCE = 3'h7;

	// reference divider ratios
	localparam logic [7:0]  TPSC_REF_80      = 8'h50;
	localparam logic [7:0]  TPSC_REF_128     = 8'h80;
	localparam logic [7:0]  TPSC_REF_64      = 8'h40;

	// status byte constant middle bits
	localparam logic [2:0]  TPSC_STAT_ONES   = 3'h7;

	// port 3 test source codes
	localparam logic [1:0]  TPSC_P3_NONE     = 2'h0;
	localparam logic [1:0]  TPSC_P3_HALFREF  = 2'h1;
	localparam logic [1:0]  TPSC_P3_HALFDIV  = 2'h2;

	// bit clock timing of the controller
	localparam int          TPSC_CLK_HZ      = 25_000_000;
	localparam int          TPSC_SCL_HZ      = 100_000;
	localparam int          TPSC_QTR_CYC     = (TPSC_CLK_HZ + 4 * TPSC_SCL_HZ - 1) / (4 * TPSC_SCL_HZ);

	// controller register offsets
	localparam logic [2:0]  TPSC_REG_CTRL    = 3'h0;
	localparam logic [2:0]  TPSC_REG_STAT    = 3'h1;
	localparam logic [2:0]  TPSC_REG_DATA0   = 3'h4;

	typedef enum logic [2:0] {TPSC_D_IDLE, TPSC_D_ADDR, TPSC_D_ADDR_ACK, TPSC_D_WR,
		TPSC_D_WR_ACK, TPSC_D_RD, TPSC_D_RD_ACK} tpsc_dev_st_t;
	typedef enum logic [1:0] {TPSC_K_CLASSIFY, TPSC_K_DIV_LOW, TPSC_K_BAND} tpsc_kind_t;
	typedef enum logic [1:0] {TPSC_PUMP_NORMAL, TPSC_PUMP_OFF, TPSC_PUMP_SINK,
		TPSC_PUMP_SOURCE} tpsc_pump_t;
	typedef enum logic [1:0] {TPSC_H_IDLE, TPSC_H_START, TPSC_H_BIT, TPSC_H_STOP} tpsc_host_st_t;

endpackage : tpsc_pkg

// ==== hdl/tpsc_bus_if.sv ====
// two-wire bus between controller and synthesizer control port
`timescale 1ns/1ps
interface tpsc_bus_if;
	logic scl;
	logic sda;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic s_sda_out;
	logic s_sda_oe;

	// open-drain wires with pull-ups: a driver only pulls low
	assign scl = m_scl_oe ? m_scl_out : 1'b1;
	assign sda = (m_sda_oe ? m_sda_out : 1'b1) & (s_sda_oe ? s_sda_out : 1'b1);

	modport host (input scl, input sda, output m_scl_out, output m_scl_oe,
		output m_sda_out, output m_sda_oe);
	modport device (input scl, input sda, output s_sda_out, output s_sda_oe);
endinterface : tpsc_bus_if

// ==== hdl/tpsc_device.sv ====
// synthesizer serial control port: bus slave, settings registers, status byte
// Contract
// - answer only address 11000 plus module bits
// - module bits from address pin level
// - read/write bit 0 means write transfer
// - write byte top bit picks divider/control
// - first byte divider or control; auto-increment
// - registers load on eighth clock of byte
// - divider is 15-bit from two bytes
// - control byte layout; pump current 20/100
// - booster bit bypasses IF filter
// - reference ratio 80, 128 or 64
// - band byte low five bits enable ports
// - test codes: pump off, ignore band, sink, source
// - port 3 carries half ref or divider
// - read: ack, then status byte MSB first
// - master ack asks for another byte
// - master no-ack ends read, releases data line
// - status: power-up, lock, 111, converter code
// - power-up flag set at reset, cleared after read
// - converter level reported as codes 0 to 4
// - reset: 100uA pump, test 001, ports off
// - port 0 low band, 1 mid, else high
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module tpsc_device
	import tpsc_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rst,
	tpsc_bus_if.device                bus,
	input  wire logic [2:0]           addr_pin_level,
	input  wire logic [3:0]           adc_level,
	input  wire logic                 loop_locked_ind,
	output logic      [14:0]          divider_ratio_bits,
	output logic                      pump_current_sel,
	output logic      [2:0]           test_sel,
	output logic                      ref_ratio_sel_a,
	output logic                      ref_ratio_sel_b,
	output logic      [7:0]           ref_divide_ratio,
	output logic                      booster_enable,
	output logic                      if_filter_bypass,
	output tpsc_pkg::tpsc_pump_t      pump_mode,
	output logic      [4:0]           port_enable,
	output logic      [1:0]           port3_test_src,
	output logic                      band_low,
	output logic                      band_mid,
	output logic                      band_high,
	output logic                      power_up_flag
);
	import tpsc_pkg::*;

	typedef struct packed {
		tpsc_dev_st_t st;
		tpsc_kind_t   kind;
		logic         scl_q;
		logic         sda_q;
		logic [3:0]   bit_cnt;
		logic [7:0]   shreg;
		logic         rw;
		logic         sda_oe;
		logic [6:0]   div_hi;
		logic [14:0]  divider;
		logic [7:0]   control;
		logic [4:0]   band;
		logic         por_flag;
		logic [1:0]   mod_addr;
		logic         strap_done;
	} tpsc_dev_state_t;

	tpsc_dev_state_t s;
	tpsc_dev_state_t next_s;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic [7:0] rx_byte;
	logic [7:0] status_byte;
	logic [2:0] converter_code;
	logic [2:0] strap_cnt;

	// counts comparator outputs of a thermometer-coded level
	function automatic logic [2:0] tpsc_therm_cnt(input logic [3:0] t);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < 4; i++)
		begin
			c = c + {2'h0, t[i]};
		end
		return c;
	endfunction : tpsc_therm_cnt

	// bus events, lines are already synchronous to mclk
	assign scl_rise   = bus.scl & ~s.scl_q;
	assign scl_fall   = ~bus.scl & s.scl_q;
	assign start_cond = bus.scl & s.scl_q & s.sda_q & ~bus.sda;
	assign stop_cond  = bus.scl & s.scl_q & ~s.sda_q & bus.sda;
	assign rx_byte    = {s.shreg[6:0], bus.sda};

	// level decoders: pin comparators at 0.1, 0.4, 0.9 and 0.15..0.6 of supply
	assign strap_cnt      = tpsc_therm_cnt({1'b0, addr_pin_level});
	assign converter_code = tpsc_therm_cnt(adc_level);
	assign status_byte    = {s.por_flag, loop_locked_ind, TPSC_STAT_ONES,
		converter_code};

	// whole state update
	always_comb
	begin
		next_s = s;
		next_s.scl_q = bus.scl;
		next_s.sda_q = bus.sda;
		// strap caught once after reset release, not at reset itself
		if (!s.strap_done)
		begin
			next_s.mod_addr = strap_cnt[1:0];
			next_s.strap_done = 1'b1;
		end
		if (start_cond)
		begin
			next_s.st = TPSC_D_ADDR;
			next_s.bit_cnt = 4'h0;
			next_s.sda_oe = 1'b0;
			next_s.kind = TPSC_K_CLASSIFY;
		end
		else if (stop_cond)
		begin
			next_s.st = TPSC_D_IDLE;
			next_s.sda_oe = 1'b0;
		end
		else
		begin
			unique case (s.st)
				TPSC_D_IDLE:
				begin
					next_s.sda_oe = 1'b0;
				end
				TPSC_D_ADDR:
				begin
					if (scl_rise)
					begin
						next_s.shreg = rx_byte;
						next_s.bit_cnt = s.bit_cnt + 4'h1;
					end
					else if (scl_fall && s.bit_cnt == 4'h8)
					begin
						// foreign addresses leave the bus untouched
						if (s.shreg[7:3] == TPSC_ADDR_FIXED && s.shreg[2:1] == s.mod_addr)
						begin
							next_s.rw = s.shreg[0];
							next_s.sda_oe = 1'b1;
							next_s.st = TPSC_D_ADDR_ACK;
						end
						else
						begin
							next_s.st = TPSC_D_IDLE;
						end
					end
				end
				TPSC_D_ADDR_ACK:
				begin
					// end of an acknowledge clock; also re-entered on master ack
					if (scl_fall)
					begin
						next_s.bit_cnt = 4'h0;
						if (s.rw)
						begin
							next_s.shreg = status_byte;
							next_s.sda_oe = ~status_byte[7];
							next_s.st = TPSC_D_RD;
						end
						else
						begin
							next_s.sda_oe = 1'b0;
							next_s.st = TPSC_D_WR;
						end
					end
				end
				TPSC_D_WR:
				begin
					if (scl_rise)
					begin
						next_s.shreg = rx_byte;
						next_s.bit_cnt = s.bit_cnt + 4'h1;
						// eighth clock of the byte commits it
						if (s.bit_cnt == 4'h7)
						begin
							unique case (s.kind)
								TPSC_K_CLASSIFY:
								begin
									if (!rx_byte[TPSC_CB_MARK])
									begin
										next_s.div_hi = rx_byte[6:0];
										next_s.kind = TPSC_K_DIV_LOW;
									end
									else
									begin
										next_s.control = rx_byte;
										next_s.kind = TPSC_K_BAND;
									end
								end
								TPSC_K_DIV_LOW:
								begin
									next_s.divider = {s.div_hi, rx_byte};
									next_s.kind = TPSC_K_CLASSIFY;
								end
								TPSC_K_BAND:
								begin
									if (test_sel != TPSC_TEST_NOBAND)
									begin
										next_s.band = rx_byte[4:0];
									end
									next_s.kind = TPSC_K_CLASSIFY;
								end
								default:
								begin
									next_s.kind = TPSC_K_CLASSIFY;
								end
							endcase
						end
					end
					else if (scl_fall && s.bit_cnt == 4'h8)
					begin
						next_s.sda_oe = 1'b1;
						next_s.st = TPSC_D_WR_ACK;
					end
				end
				TPSC_D_WR_ACK:
				begin
					if (scl_fall)
					begin
						next_s.sda_oe = 1'b0;
						next_s.bit_cnt = 4'h0;
						next_s.st = TPSC_D_WR;
					end
				end
				TPSC_D_RD:
				begin
					// data changes only while scl is low
					if (scl_fall)
					begin
						next_s.bit_cnt = s.bit_cnt + 4'h1;
						if (s.bit_cnt == 4'h7)
						begin
							next_s.sda_oe = 1'b0;
							next_s.st = TPSC_D_RD_ACK;
						end
						else
						begin
							next_s.shreg = {s.shreg[6:0], 1'b0};
							next_s.sda_oe = ~s.shreg[6];
						end
					end
				end
				TPSC_D_RD_ACK:
				begin
					if (scl_rise)
					begin
						if (!bus.sda)
						begin
							next_s.st = TPSC_D_ADDR_ACK;
						end
						else
						begin
							next_s.por_flag = 1'b0;
							next_s.st = TPSC_D_IDLE;
						end
					end
				end
				default:
				begin
					next_s.st = TPSC_D_IDLE;
				end
			endcase
		end
	end

	// registered state, power-on values on reset
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= TPSC_D_IDLE;
			s.kind <= TPSC_K_CLASSIFY;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
			s.divider <= TPSC_DIV_RESET;
			s.control <= TPSC_CTRL_RESET;
			s.band <= TPSC_BAND_RESET;
			s.por_flag <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	// bus drive: open drain, only ever pulls low
	assign bus.s_sda_out = 1'b0;
	assign bus.s_sda_oe  = s.sda_oe;

	// settings decoded from the registers
	assign divider_ratio_bits = s.divider;
	assign pump_current_sel   = s.control[TPSC_CB_PUMP];
	assign test_sel           = s.control[TPSC_CB_TEST_HI:TPSC_CB_TEST_LO];
	assign ref_ratio_sel_a    = s.control[TPSC_CB_RSA];
	assign ref_ratio_sel_b    = s.control[TPSC_CB_RSB];
	assign booster_enable     = s.control[TPSC_CB_BOOST];
	assign if_filter_bypass   = s.control[TPSC_CB_BOOST];
	assign power_up_flag      = s.por_flag;
	assign ref_divide_ratio   = !ref_ratio_sel_b ? TPSC_REF_80 :
		(ref_ratio_sel_a ? TPSC_REF_64 : TPSC_REF_128);

	// pump and port 3 test modes; port 3 is lost to general use there
	always_comb
	begin
		pump_mode = TPSC_PUMP_NORMAL;
		port3_test_src = TPSC_P3_NONE;
		unique case (test_sel)
			TPSC_TEST_PUMPOFF:
			begin
				pump_mode = TPSC_PUMP_OFF;
				port3_test_src = TPSC_P3_HALFDIV;
			end
			TPSC_TEST_SINK:     pump_mode = TPSC_PUMP_SINK;
			TPSC_TEST_SOURCE:   pump_mode = TPSC_PUMP_SOURCE;
			TPSC_TEST_HALFREF:  port3_test_src = TPSC_P3_HALFREF;
			TPSC_TEST_HALFDIV:  port3_test_src = TPSC_P3_HALFDIV;
			TPSC_TEST_NORM0, TPSC_TEST_NORM1, TPSC_TEST_NOBAND:
			begin
				pump_mode = TPSC_PUMP_NORMAL;
			end
		endcase
	end

	// port enables and band choice
	assign port_enable = {s.band[4],
		s.band[3] & (port3_test_src == TPSC_P3_NONE), s.band[2:0]};
	assign band_low  = s.band[0];
	assign band_mid  = s.band[1];
	assign band_high = ~s.band[0] & ~s.band[1];

endmodule : tpsc_device

// ==== hdl/tpsc_host.sv ====
// bus controller end: software registers drive write and read transfers
`timescale 1ns/1ps
module tpsc_host
	import tpsc_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rst,
	tpsc_bus_if.host                  bus,
	input  wire logic [2:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [7:0]           reg_rdata
);
	import tpsc_pkg::*;

	localparam logic [6:0] QTR_LAST = 7'(TPSC_QTR_CYC - 1);

	typedef struct packed {
		tpsc_host_st_t  st;
		logic [6:0]     tmr;
		logic [1:0]     qtr;
		logic [2:0]     step;
		logic [2:0]     byte_idx;
		logic [3:0]     bit_idx;
		logic [2:0]     count;
		logic           rd;
		logic [1:0]     maddr;
		logic           scl_low;
		logic           sda_low;
		logic [7:0]     rx;
		logic           nack;
		logic           addr_nack;
		logic           data_nack;
		logic [3:0][7:0] data;
		logic [7:0]     rdata;
	} tpsc_host_state_t;

	tpsc_host_state_t s;
	tpsc_host_state_t next_s;

	logic       tick;
	logic       receiving;
	logic [7:0] tx_byte;
	logic       drive_low;

	assign tick      = (s.tmr == QTR_LAST);
	// address byte always goes out; data bytes come in only on reads
	assign receiving = s.rd && (s.byte_idx != 3'h0);
	assign tx_byte   = (s.byte_idx == 3'h0) ? {TPSC_ADDR_FIXED, s.maddr, s.rd} :
		s.data[s.byte_idx[1:0] - 2'h1];

	// what sda does during the coming bit; ack only when more is wanted
	always_comb
	begin
		drive_low = 1'b0;
		if (s.bit_idx < 4'h8)
		begin
			drive_low = !receiving && !tx_byte[3'(4'h7 - s.bit_idx)];
		end
		else if (receiving)
		begin
			drive_low = (s.byte_idx != s.count);
		end
	end

	always_comb
	begin
		next_s = s;
		next_s.rdata = 8'h00;
		next_s.tmr = (s.st == TPSC_H_IDLE || tick) ? 7'h00 : s.tmr + 7'h01;
		// software port: reads answer in the next cycle only
		if (reg_rd)
		begin
			if (reg_addr == TPSC_REG_STAT)
			begin
				next_s.rdata = {5'h00, s.data_nack, s.addr_nack, s.st != TPSC_H_IDLE};
			end
			else if (reg_addr >= TPSC_REG_DATA0)
			begin
				next_s.rdata = s.data[reg_addr[1:0]];
			end
		end
		if (reg_wr && reg_addr >= TPSC_REG_DATA0)
		begin
			next_s.data[reg_addr[1:0]] = reg_wdata;
		end
		unique case (s.st)
			TPSC_H_IDLE:
			begin
				if (reg_wr && reg_addr == TPSC_REG_CTRL && reg_wdata[2:0] != 3'h0)
				begin
					next_s.count = (reg_wdata[2:0] > 3'h4) ? 3'h4 : reg_wdata[2:0];
					next_s.rd = reg_wdata[3];
					next_s.maddr = reg_wdata[5:4];
					next_s.addr_nack = 1'b0;
					next_s.data_nack = 1'b0;
					next_s.byte_idx = 3'h0;
					next_s.bit_idx = 4'h0;
					next_s.step = 3'h0;
					next_s.st = TPSC_H_START;
				end
			end
			TPSC_H_START:
			begin
				// sda falls while scl high, then scl falls
				if (tick)
				begin
					next_s.step = s.step + 3'h1;
					if (s.step == 3'h0)
					begin
						next_s.sda_low = 1'b1;
					end
					else
					begin
						next_s.scl_low = 1'b1;
						next_s.qtr = 2'h0;
						next_s.sda_low = drive_low;
						next_s.st = TPSC_H_BIT;
					end
				end
			end
			TPSC_H_BIT:
			begin
				if (tick)
				begin
					next_s.qtr = s.qtr + 2'h1;
					unique case (s.qtr)
						2'h0: next_s.scl_low = 1'b0;
						2'h1:
						begin
							if (s.bit_idx < 4'h8)
							begin
								next_s.rx = {s.rx[6:0], bus.sda};
							end
							else
							begin
								next_s.nack = bus.sda;
							end
						end
						2'h2: next_s.scl_low = 1'b1;
						2'h3:
						begin
							next_s.bit_idx = s.bit_idx + 4'h1;
							if (s.bit_idx == 4'h8)
							begin
								next_s.bit_idx = 4'h0;
								if (receiving)
								begin
									next_s.data[s.byte_idx[1:0] - 2'h1] = s.rx;
								end
								if (!receiving && s.nack)
								begin
									next_s.addr_nack = (s.byte_idx == 3'h0);
									next_s.data_nack = (s.byte_idx != 3'h0);
								end
								if ((!receiving && s.nack) || s.byte_idx == s.count)
								begin
									next_s.st = TPSC_H_STOP;
									next_s.step = 3'h0;
								end
								else
								begin
									next_s.byte_idx = s.byte_idx + 3'h1;
								end
							end
						end
					endcase
				end
				// sda is pulled low a quarter after scl falls, then takes its bit as scl rises
				if (tick && s.qtr == 2'h3)
				begin
					next_s.sda_low = 1'b1;
				end
				else if (tick && s.qtr == 2'h0 && s.step != 3'h7)
				begin
					next_s.sda_low = drive_low;
				end
			end
			TPSC_H_STOP:
			begin
				// scl rises, then sda rises while scl high
				if (tick)
				begin
					next_s.step = s.step + 3'h1;
					if (s.step == 3'h0)
					begin
						next_s.scl_low = 1'b0;
					end
					else if (s.step == 3'h1)
					begin
						next_s.sda_low = 1'b0;
					end
					else
					begin
						next_s.st = TPSC_H_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= TPSC_H_IDLE;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign bus.m_scl_out = 1'b0;
	assign bus.m_scl_oe  = s.scl_low;
	assign bus.m_sda_out = 1'b0;
	assign bus.m_sda_oe  = s.sda_low;
	assign reg_rdata     = s.rdata;

endmodule : tpsc_host

// ==== testbench/tpsc_props.sv ====
// bus and settings checks for the synthesizer control port
`timescale 1ns/1ps
module tpsc_props
	import tpsc_pkg::*;
(
	input wire logic                 mclk,
	input wire logic                 rst,
	input wire logic                 scl,
	input wire logic                 sda,
	input wire logic                 s_sda_oe,
	input wire logic [2:0]           test_sel,
	input wire logic                 ref_ratio_sel_a,
	input wire logic                 ref_ratio_sel_b,
	input wire logic [7:0]           ref_divide_ratio,
	input wire tpsc_pkg::tpsc_pump_t pump_mode,
	input wire logic [4:0]           port_enable,
	input wire logic [1:0]           port3_test_src,
	input wire logic                 band_low,
	input wire logic                 band_mid,
	input wire logic                 band_high,
	input wire logic                 power_up_flag
);
	default clocking clk_main @(posedge mclk);
	endclocking
	default disable iff (rst);

	// data may only move while the clock line is low, else it reads as start or stop
	property p_sda_scl_low;
		scl && $past(scl) |-> $stable(s_sda_oe);
	endproperty
	a_sda_scl_low: assert property (p_sda_scl_low)
		else $error("device data line moved while clock high");

	// longest legal low run is ack plus two zero status bits
	property p_ack_bound;
		$rose(s_sda_oe) |-> ##[1:800] !s_sda_oe;
	endproperty
	a_ack_bound: assert property (p_ack_bound)
		else $error("device held data line too long");

	property p_ref;
		ref_divide_ratio == (!ref_ratio_sel_b ? TPSC_REF_80 :
			(ref_ratio_sel_a ? TPSC_REF_64 : TPSC_REF_128));
	endproperty
	a_ref: assert property (p_ref)
		else $error("reference ratio wrong");

	property p_pump_off;
		test_sel == TPSC_TEST_PUMPOFF |-> pump_mode == TPSC_PUMP_OFF
			&& port3_test_src == TPSC_P3_HALFDIV && !port_enable[3];
	endproperty
	a_pump_off: assert property (p_pump_off)
		else $error("pump off mode wrong");

	property p_pump_force;
		test_sel[2:1] == 2'h3 |-> pump_mode == (test_sel[0] ? TPSC_PUMP_SOURCE : TPSC_PUMP_SINK);
	endproperty
	a_pump_force: assert property (p_pump_force)
		else $error("forced pump mode wrong");

	property p_p3_test;
		test_sel[2:1] == 2'h2 |-> !port_enable[3]
			&& port3_test_src == (test_sel[0] ? TPSC_P3_HALFDIV : TPSC_P3_HALFREF);
	endproperty
	a_p3_test: assert property (p_p3_test)
		else $error("port 3 test output wrong");

	property p_band;
		band_high == !(band_low || band_mid) && band_low == port_enable[0]
			&& band_mid == port_enable[1];
	endproperty
	a_band: assert property (p_band)
		else $error("band select wrong");

	// settings load on the eighth clock rise, so the clock line is high then
	property p_load_scl;
		$changed(test_sel) |-> scl;
	endproperty
	a_load_scl: assert property (p_load_scl)
		else $error("control loaded outside clock high");

	property p_por_clear;
		$fell(power_up_flag) |-> scl && sda;
	endproperty
	a_por_clear: assert property (p_por_clear)
		else $error("power-up flag cleared without master nack");

	c_por: cover property ($fell(power_up_flag));
	c_noband: cover property (test_sel == TPSC_TEST_NOBAND);
	c_ack: cover property ($rose(s_sda_oe));
endmodule : tpsc_props

// ==== testbench/tb_top.sv ====
// bench: host registers drive the device across the shared two-wire bus
`timescale 1ns/1ps
module tb_top;
	import tpsc_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic [3:0]  adc_level = 4'h7;
	logic        loop_locked_ind = 1'b1;
	logic [14:0] divider_ratio_bits;
	logic        pump_current_sel;
	logic [2:0]  test_sel;
	logic        ref_ratio_sel_a;
	logic        ref_ratio_sel_b;
	logic [7:0]  ref_divide_ratio;
	logic        booster_enable;
	logic        if_filter_bypass;
	tpsc_pump_t  pump_mode;
	logic [4:0]  port_enable;
	logic [1:0]  port3_test_src;
	logic        band_low;
	logic        band_mid;
	logic        band_high;
	logic        power_up_flag;
	int          n_fail = 0;
	int          total_checks = 0;
	logic [7:0]  rd;
	logic [4:0]  band;
	logic [7:0]  ctl_val;

	tpsc_bus_if bus ();
	tpsc_host u_tpsc_host (.mclk(mclk), .rst(rst), .bus(bus), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// strap reads as an open pin, module address 1
	tpsc_device u_tpsc_device (.mclk(mclk), .rst(rst), .bus(bus), .addr_pin_level(3'h1),
		.adc_level(adc_level), .loop_locked_ind(loop_locked_ind),
		.divider_ratio_bits(divider_ratio_bits), .pump_current_sel(pump_current_sel),
		.test_sel(test_sel), .ref_ratio_sel_a(ref_ratio_sel_a), .ref_ratio_sel_b(ref_ratio_sel_b),
		.ref_divide_ratio(ref_divide_ratio), .booster_enable(booster_enable),
		.if_filter_bypass(if_filter_bypass), .pump_mode(pump_mode), .port_enable(port_enable),
		.port3_test_src(port3_test_src), .band_low(band_low), .band_mid(band_mid),
		.band_high(band_high), .power_up_flag(power_up_flag));
	tpsc_props u_tpsc_props (.mclk(mclk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
		.s_sda_oe(bus.s_sda_oe), .test_sel(test_sel), .ref_ratio_sel_a(ref_ratio_sel_a),
		.ref_ratio_sel_b(ref_ratio_sel_b), .ref_divide_ratio(ref_divide_ratio),
		.pump_mode(pump_mode), .port_enable(port_enable), .port3_test_src(port3_test_src),
		.band_low(band_low), .band_mid(band_mid), .band_high(band_high),
		.power_up_flag(power_up_flag));

	// 25 MHz system clock
	always #20 mclk = ~mclk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rdr(input logic [2:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rd = reg_rdata;
	endtask : rdr

	// start a transfer and poll until busy drops; status is left in rd
	task automatic xfer(input logic [7:0] ctl);
		wr(TPSC_REG_CTRL, ctl);
		for (int i = 0; i < 20000; i++)
		begin
			rdr(TPSC_REG_STAT);
			if (rd[0] === 1'b0)
				break;
		end
	endtask : xfer

	// watchdog sized for about 69k cycles of traffic
	initial
	begin
		repeat (98000) @(posedge mclk);
		n_fail++;
		$display("mismatch at %0t: transfer hung", $time);
		finish_test();
	end

	initial
	begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		check({pump_current_sel, test_sel, booster_enable, port_enable, band_high, power_up_flag},
			{1'b1, 3'h1, 1'b0, 5'h00, 1'b1, 1'b1});
		check(ref_divide_ratio, TPSC_REF_80);
		// full write: divider pair, then control and band
		wr(TPSC_REG_DATA0, 8'h5A);
		wr(TPSC_REG_DATA0 + 3'h1, 8'hC3);
		wr(TPSC_REG_DATA0 + 3'h2, 8'h83);
		wr(TPSC_REG_DATA0 + 3'h3, 8'hE5);
		xfer({2'h0, 2'h1, 1'b0, 3'h4});
		check(rd[2:0], 3'h0);
		check(divider_ratio_bits, 15'h5AC3);
		check({pump_current_sel, test_sel, ref_ratio_sel_a, ref_ratio_sel_b, booster_enable,
			if_filter_bypass}, {1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1});
		check({port_enable, band_low, band_mid, band_high}, {5'h05, 3'h4});
		// another module address must be refused and change nothing
		wr(TPSC_REG_DATA0, 8'h01);
		xfer({2'h0, 2'h2, 1'b0, 3'h2});
		check(rd[1:0], 2'h2);
		check(divider_ratio_bits, 15'h5AC3);
		// control-first partial writes over every test code from 2 to 7
		band = 5'h05;
		for (int c = 2; c < 8; c++)
		begin
			ctl_val = {1'b1, c[0], c[2:0], c[1], c[0], c[1]};
			wr(TPSC_REG_DATA0, ctl_val);
			wr(TPSC_REG_DATA0 + 3'h1, {3'h7, c[1:0], c[2:0]});
			xfer({2'h0, 2'h1, 1'b0, 3'h2});
			if (c != 3)
				band = {c[1:0], c[2:0]};
			check(test_sel, c[2:0]);
			check(port_enable, band & ((c == 2 || c == 4 || c == 5) ? 5'h17 : 5'h1F));
			check({band_low, band_mid, band_high}, {band[0], band[1], band[1:0] == 2'h0});
			check({pump_current_sel, if_filter_bypass}, {c[0], c[1]});
		end
		check({bus.scl, bus.sda}, 2'h3);
		// two-byte read: master acks the first, nacks the last
		xfer({2'h0, 2'h1, 1'b1, 3'h2});
		check(rd[1:0], 2'h0);
		rdr(TPSC_REG_DATA0);
		check(rd, 8'hFB);
		rdr(TPSC_REG_DATA0 + 3'h1);
		check(rd, 8'hFB);
		check(power_up_flag, 1'b0);
		@(posedge mclk);
		loop_locked_ind <= 1'b0;
		adc_level <= 4'hF;
		xfer({2'h0, 2'h1, 1'b1, 3'h1});
		rdr(TPSC_REG_DATA0);
		check(rd, 8'h3C);
		finish_test();
	end
endmodule : tb_top
